// file: rtl/cab_core.sv
// Register access over Avalon-MM and the register offsets are this design's own decisions.
module cab_core #(
  parameter int PC_W = 21
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  output logic      [PC_W-1:0]            prog_addr,
  input  wire logic [15:0]                prog_data,
  output cab_pkg::cab_dmem_req_type       dmem_req,
  input  wire logic [7:0]                 dmem_rdata
);

  logic [1:0]              ctrl_q;
  logic [7:0]              w_q;
  logic [4:0]              status_q;
  logic [3:0]              bank_sel_q;
  logic [11:0]             index_base_q;
  logic [PC_W-1:0]         pc_q;
  logic [1:0]              phase_q;
  logic                    flush_q;
  logic [15:0]             instr_q;
  cab_pkg::cab_op_type     op_q;
  logic [7:0]              opnd_q;
  logic [7:0]              res_q;
  logic [4:0]              new_status_q;
  logic                    to_w_q;
  logic                    take_q;
  cab_pkg::cab_dmem_req_type dmem_q;
  logic [31:0]             rdata_q;
  logic                    wait_q;

  logic                    step;
  logic                    commit;
  logic                    bus_req;
  logic                    bus_wr;
  logic [7:0]              alu_res;
  logic [4:0]              alu_status;
  logic                    alu_to_w;
  logic                    alu_file_wr;
  logic                    alu_take;
  logic [8:0]              sum9;
  logic [4:0]              sum_lo;
  logic [PC_W-1:0]         pc_next;

  // Map an instruction word onto the operation it names.
  function automatic cab_pkg::cab_op_type decode_op(input logic [15:0] iw);
    if (iw[15:10] == cab_pkg::OPC_ADD_W_CARRY_TO_FILE) begin
      decode_op = cab_pkg::OP_ADD_W_CARRY_TO_FILE;
    end else if (iw[15:8] == cab_pkg::OPC_AND_LITERAL_TO_ACC) begin
      decode_op = cab_pkg::OP_AND_LITERAL_TO_ACC;
    end else if (iw[15:10] == cab_pkg::OPC_AND_ACC_WITH_FILE) begin
      decode_op = cab_pkg::OP_AND_ACC_WITH_FILE;
    end else if (iw[15:8] == cab_pkg::OPC_BRANCH_ON_CARRY_SET) begin
      decode_op = cab_pkg::OP_BRANCH_ON_CARRY_SET;
    end else if (iw[15:8] == cab_pkg::OPC_BRANCH_ON_NEG_SET) begin
      decode_op = cab_pkg::OP_BRANCH_ON_NEGATIVE_SET;
    end else if (iw[15:12] == cab_pkg::OPC_CLEAR_FILE_BIT) begin
      decode_op = cab_pkg::OP_CLEAR_FILE_BIT;
    end else begin
      decode_op = cab_pkg::OP_NOP;
    end
  endfunction : decode_op

  // Form the data address of a file operand from the bank bit and the file field.
  function automatic logic [11:0] file_addr(input logic [15:0] iw, input logic ext, input logic [3:0] bsel,
                                            input logic [11:0] ibase);
    if (iw[cab_pkg::BANK_BIT]) begin
      file_addr = {bsel, iw[7:0]};
    end else if (ext && (iw[7:0] <= cab_pkg::INDEXED_F_MAX)) begin
      file_addr = 12'(ibase + {4'h0, iw[7:0]});
    end else if (iw[7:0] <= cab_pkg::INDEXED_F_MAX) begin
      file_addr = {4'h0, iw[7:0]};
    end else begin
      file_addr = {cab_pkg::ACCESS_HI_PAGE, iw[7:0]};
    end
  endfunction : file_addr

  // The core only advances when enabled and set running; the bus is frozen by the clock enable alone.
  assign step    = clk_en && ctrl_q[cab_pkg::CTRL_RUN];
  assign commit  = step && (phase_q == cab_pkg::PH_Q4);
  assign bus_req = avs_read || avs_write;
  assign bus_wr  = clk_en && avs_write && !wait_q;

  // Quarter phase counter; one instruction cycle is four enabled clocks.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= cab_pkg::PH_Q1;
    end else if (step) begin
      phase_q <= 2'(phase_q + 2'h1);
    end
  end

  // Q1 decode: a flushed cycle latches a no-operation so the fetched word is discarded.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q <= 16'h0000;
      op_q    <= cab_pkg::OP_NOP;
    end else if (step && (phase_q == cab_pkg::PH_Q1)) begin
      instr_q <= prog_data;
      op_q    <= flush_q ? cab_pkg::OP_NOP : decode_op(prog_data);
    end
  end

  // Data memory request: address set after decode, write strobe held through Q4 only.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem_q <= '0;
    end else if (step) begin
      if (phase_q == cab_pkg::PH_Q1) begin
        dmem_q.addr <= file_addr(prog_data, ctrl_q[cab_pkg::CTRL_EXT], bank_sel_q, index_base_q);
      end
      if (phase_q == cab_pkg::PH_Q3) begin
        dmem_q.we    <= alu_file_wr;
        dmem_q.wdata <= alu_res;
      end else begin
        dmem_q.we <= 1'b0;
      end
    end
  end

  // Q2 operand read: file data or the literal carried in the instruction.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd_q <= 8'h00;
    end else if (step && (phase_q == cab_pkg::PH_Q2)) begin
      opnd_q <= (op_q == cab_pkg::OP_AND_LITERAL_TO_ACC) ? instr_q[7:0] : dmem_rdata;
    end
  end

  // Q3 arithmetic and flag computation.
  assign sum9   = {1'b0, w_q} + {1'b0, opnd_q} + {8'h00, status_q[cab_pkg::ST_CARRY]};
  assign sum_lo = {1'b0, w_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, status_q[cab_pkg::ST_CARRY]};

  always_comb begin
    alu_res     = opnd_q;
    alu_status  = status_q;
    alu_to_w    = 1'b0;
    alu_file_wr = 1'b0;
    alu_take    = 1'b0;
    case (op_q)
      cab_pkg::OP_ADD_W_CARRY_TO_FILE: begin
        alu_res                          = sum9[7:0];
        alu_status[cab_pkg::ST_CARRY]    = sum9[8];
        alu_status[cab_pkg::ST_DIGIT]    = sum_lo[4];
        alu_status[cab_pkg::ST_ZERO]     = (sum9[7:0] == 8'h00);
        alu_status[cab_pkg::ST_OVERFLOW] = (w_q[7] == opnd_q[7]) && (sum9[7] != w_q[7]);
        alu_status[cab_pkg::ST_NEGATIVE] = sum9[7];
        alu_to_w                         = !instr_q[cab_pkg::DEST_BIT];
        alu_file_wr                      = instr_q[cab_pkg::DEST_BIT];
      end
      cab_pkg::OP_AND_LITERAL_TO_ACC: begin
        alu_res                          = w_q & opnd_q;
        alu_status[cab_pkg::ST_ZERO]     = ((w_q & opnd_q) == 8'h00);
        alu_status[cab_pkg::ST_NEGATIVE] = w_q[7] & opnd_q[7];
        alu_to_w                         = 1'b1;
      end
      cab_pkg::OP_AND_ACC_WITH_FILE: begin
        alu_res                          = w_q & opnd_q;
        alu_status[cab_pkg::ST_ZERO]     = ((w_q & opnd_q) == 8'h00);
        alu_status[cab_pkg::ST_NEGATIVE] = w_q[7] & opnd_q[7];
        alu_to_w                         = !instr_q[cab_pkg::DEST_BIT];
        alu_file_wr                      = instr_q[cab_pkg::DEST_BIT];
      end
      cab_pkg::OP_BRANCH_ON_CARRY_SET: begin
        alu_take = status_q[cab_pkg::ST_CARRY];
      end
      cab_pkg::OP_BRANCH_ON_NEGATIVE_SET: begin
        alu_take = status_q[cab_pkg::ST_NEGATIVE];
      end
      cab_pkg::OP_CLEAR_FILE_BIT: begin
        alu_res                    = opnd_q;
        alu_res[instr_q[11:9]]     = 1'b0;
        alu_file_wr                = 1'b1;
      end
      default: begin
        alu_res = opnd_q;
      end
    endcase
  end

  // Q3 results are held so that Q4 writes them without a long combinational path.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q        <= 8'h00;
      new_status_q <= cab_pkg::STATUS_RESET;
      to_w_q       <= 1'b0;
      take_q       <= 1'b0;
    end else if (step && (phase_q == cab_pkg::PH_Q3)) begin
      res_q        <= alu_res;
      new_status_q <= alu_status;
      to_w_q       <= alu_to_w;
      take_q       <= alu_take;
    end
  end

  // Offset is doubled and sign extended; the counter holds the branch address, so two is added before the offset.
  assign pc_next = take_q ? PC_W'(pc_q + PC_W'(2) + {{(PC_W-9){instr_q[7]}}, instr_q[7:0], 1'b0})
                          : PC_W'(pc_q + PC_W'(2));

  // Program counter: held still in a flushed cycle while the target is fetched.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
    end else if (commit && !flush_q) begin
      pc_q <= pc_next;
    end else if (bus_wr && (avs_address == cab_pkg::OFS_PC) && !ctrl_q[cab_pkg::CTRL_RUN]) begin
      pc_q <= PC_W'({avs_writedata[PC_W-1:1], 1'b0});
    end
  end

  // A taken branch spends the following instruction cycle as a no-operation.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flush_q <= 1'b0;
    end else if (commit) begin
      flush_q <= !flush_q && take_q;
    end
  end

  // Working register: a core write in Q4 wins over a bus write in the same clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= cab_pkg::WREG_RESET;
    end else if (commit && to_w_q && !flush_q) begin
      w_q <= res_q;
    end else if (bus_wr && (avs_address == cab_pkg::OFS_WREG) && avs_byteenable[0]) begin
      w_q <= avs_writedata[7:0];
    end
  end

  // Status flags: each instruction's Q3 image already leaves untouched bits as they were.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= cab_pkg::STATUS_RESET;
    end else if (commit && !flush_q && (op_q != cab_pkg::OP_NOP)) begin
      status_q <= new_status_q;
    end else if (bus_wr && (avs_address == cab_pkg::OFS_STATUS) && avs_byteenable[0]) begin
      status_q <= avs_writedata[4:0];
    end
  end

  // Configuration registers written only from the bus.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= cab_pkg::CTRL_RESET;
      bank_sel_q   <= 4'h0;
      index_base_q <= 12'h000;
    end else if (bus_wr) begin
      if ((avs_address == cab_pkg::OFS_CTRL) && avs_byteenable[0]) begin
        ctrl_q <= avs_writedata[1:0];
      end else if ((avs_address == cab_pkg::OFS_BANK_SEL) && avs_byteenable[0]) begin
        bank_sel_q <= avs_writedata[3:0];
      end else if (avs_address == cab_pkg::OFS_INDEX_BASE) begin
        index_base_q <= {avs_byteenable[1] ? avs_writedata[11:8] : index_base_q[11:8],
                         avs_byteenable[0] ? avs_writedata[7:0] : index_base_q[7:0]}; // Both lanes may land at once.
      end
    end
  end

  // Bus answer: waitrequest drops for exactly one clock, one clock after the request appears.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      wait_q <= !(bus_req && wait_q);
      if (avs_read && wait_q) begin
        if (avs_address == cab_pkg::OFS_CTRL) begin
          rdata_q <= {30'h0, ctrl_q};
        end else if (avs_address == cab_pkg::OFS_WREG) begin
          rdata_q <= {24'h0, w_q};
        end else if (avs_address == cab_pkg::OFS_STATUS) begin
          rdata_q <= {27'h0, status_q};
        end else if (avs_address == cab_pkg::OFS_BANK_SEL) begin
          rdata_q <= {28'h0, bank_sel_q};
        end else if (avs_address == cab_pkg::OFS_INDEX_BASE) begin
          rdata_q <= {20'h0, index_base_q};
        end else if (avs_address == cab_pkg::OFS_PC) begin
          rdata_q <= 32'(pc_q);
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign prog_addr       = pc_q;
  assign dmem_req        = dmem_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_addc_result: assert property (commit && !flush_q && op_q == cab_pkg::OP_ADD_W_CARRY_TO_FILE && to_w_q
    |=> w_q == 8'($past(res_q)) && status_q[cab_pkg::ST_CARRY] == $past(new_status_q[cab_pkg::ST_CARRY]))
    else $error("add with carry result or carry not committed");
  chk_addc_sum: assert property (step && phase_q == cab_pkg::PH_Q3 && op_q == cab_pkg::OP_ADD_W_CARRY_TO_FILE
    |=> {new_status_q[cab_pkg::ST_CARRY], res_q} == {1'b0, $past(w_q)} + {1'b0, $past(opnd_q)}
        + {8'h00, $past(status_q[cab_pkg::ST_CARRY])})
    else $error("add with carry sum is wrong");
  chk_dest_select: assert property (step && phase_q == cab_pkg::PH_Q3 && op_q == cab_pkg::OP_AND_ACC_WITH_FILE
    |=> dmem_q.we == instr_q[cab_pkg::DEST_BIT] && to_w_q == !instr_q[cab_pkg::DEST_BIT])
    else $error("destination bit not honoured");
  chk_bank_addr: assert property (step && phase_q == cab_pkg::PH_Q1 && prog_data[cab_pkg::BANK_BIT] && !flush_q
    |=> dmem_q.addr == {$past(bank_sel_q), $past(prog_data[7:0])})
    else $error("banked address wrong");
  chk_indexed_addr: assert property (step && phase_q == cab_pkg::PH_Q1 && !prog_data[cab_pkg::BANK_BIT]
    && ctrl_q[cab_pkg::CTRL_EXT] && prog_data[7:0] <= cab_pkg::INDEXED_F_MAX
    |=> dmem_q.addr == 12'($past(index_base_q) + {4'h0, $past(prog_data[7:0])}))
    else $error("indexed literal offset address wrong");
  chk_andl_flags: assert property (commit && !flush_q && op_q == cab_pkg::OP_AND_LITERAL_TO_ACC
    |=> w_q == 8'($past(res_q)) && status_q[3:0] == {$past(status_q[3]), $past(new_status_q[2]),
        $past(status_q[1:0])})
    else $error("and literal changed wrong flags");
  chk_andf_flags: assert property (commit && !flush_q && op_q == cab_pkg::OP_AND_ACC_WITH_FILE
    |=> status_q[cab_pkg::ST_CARRY] == $past(status_q[cab_pkg::ST_CARRY])
        && status_q[cab_pkg::ST_OVERFLOW] == $past(status_q[cab_pkg::ST_OVERFLOW]))
    else $error("and with file changed carry or overflow");
  chk_branch_flags: assert property (commit && !flush_q && (op_q == cab_pkg::OP_BRANCH_ON_CARRY_SET
    || op_q == cab_pkg::OP_BRANCH_ON_NEGATIVE_SET || op_q == cab_pkg::OP_CLEAR_FILE_BIT) && !bus_wr
    |=> $stable(status_q))
    else $error("branch or bit clear changed status");
  chk_branch_target: assert property (commit && !flush_q && take_q
    |=> pc_q == PC_W'($past(pc_q) + PC_W'(2) + {{(PC_W-9){$past(instr_q[7])}}, $past(instr_q[7:0]), 1'b0}))
    else $error("branch target wrong");
  chk_untaken_step: assert property (commit && !flush_q && !take_q |=> pc_q == PC_W'($past(pc_q) + PC_W'(2))
    && !flush_q)
    else $error("untaken instruction did not advance by one word");
  chk_taken_nop: assert property (commit && !flush_q && take_q |=> flush_q && $stable(w_q))
    else $error("taken branch did not insert a no-operation cycle");
  chk_bit_clear: assert property (step && phase_q == cab_pkg::PH_Q3 && op_q == cab_pkg::OP_CLEAR_FILE_BIT
    |=> dmem_q.we && dmem_q.wdata[instr_q[11:9]] == 1'b0)
    else $error("bit clear did not write a cleared bit");
  chk_phase_wrap: assert property (commit |=> phase_q == cab_pkg::PH_Q1 && !dmem_q.we)
    else $error("phase did not wrap to the first quarter");

  cov_addc: cover property (commit && op_q == cab_pkg::OP_ADD_W_CARRY_TO_FILE && !flush_q);
  cov_carry_branch_taken: cover property (commit && op_q == cab_pkg::OP_BRANCH_ON_CARRY_SET && take_q && !flush_q);
  cov_neg_branch_untaken: cover property (commit && op_q == cab_pkg::OP_BRANCH_ON_NEGATIVE_SET && !take_q);
  cov_bit_clear: cover property (dmem_q.we && op_q == cab_pkg::OP_CLEAR_FILE_BIT);

endmodule : cab_core

// file: shared/cab_pkg.sv
package cab_pkg;

  // Instruction opcode fields, matched against the top bits of the word.
  localparam logic [5:0] OPC_ADD_W_CARRY_TO_FILE  = 6'h08;
  localparam logic [7:0] OPC_AND_LITERAL_TO_ACC   = 8'h0b;
  localparam logic [5:0] OPC_AND_ACC_WITH_FILE    = 6'h05;
  localparam logic [7:0] OPC_BRANCH_ON_CARRY_SET  = 8'he2;
  localparam logic [7:0] OPC_BRANCH_ON_NEG_SET    = 8'he6;
  localparam logic [3:0] OPC_CLEAR_FILE_BIT       = 4'h9;

  // Instruction field positions.
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;

  // Indexed literal offset applies to file addresses up to this value.
  localparam logic [7:0] INDEXED_F_MAX = 8'h5f;
  // Access bank file addresses above INDEXED_F_MAX map onto the top page of data space.
  localparam logic [3:0] ACCESS_HI_PAGE = 4'hf;

  // Status register bit positions.
  localparam int ST_CARRY    = 0;
  localparam int ST_DIGIT    = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_NEGATIVE = 4;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_CTRL       = 5'h00;
  localparam logic [4:0] OFS_WREG       = 5'h04;
  localparam logic [4:0] OFS_STATUS     = 5'h08;
  localparam logic [4:0] OFS_BANK_SEL   = 5'h0c;
  localparam logic [4:0] OFS_INDEX_BASE = 5'h10;
  localparam logic [4:0] OFS_PC         = 5'h14;

  // Control bit positions and values after reset.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam logic [1:0] CTRL_RESET   = 2'h0;
  localparam logic [7:0] WREG_RESET   = 8'h00;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // Quarter phases of one instruction cycle.
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ADD_W_CARRY_TO_FILE,
    OP_AND_LITERAL_TO_ACC,
    OP_AND_ACC_WITH_FILE,
    OP_BRANCH_ON_CARRY_SET,
    OP_BRANCH_ON_NEGATIVE_SET,
    OP_CLEAR_FILE_BIT
  } cab_op_type;

  // One data memory access as presented to the core data memory.
  typedef struct packed {
    logic [11:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } cab_dmem_req_type;

endpackage : cab_pkg

// file: bench/cab_mem_model.sv
module cab_mem_model #(
  parameter int PC_W = 21
) (
  input  wire logic                 sys_clk,
  input  wire logic                 clk_en,
  input  wire logic [PC_W-1:0]      prog_addr,
  output logic      [15:0]          prog_data,
  input  wire cab_pkg::cab_dmem_req_type dmem_req,
  output logic      [7:0]           dmem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] prog_mem [0:63];
  logic [7:0]  data_mem [0:4095];

  // Words past the loaded image read as an unused opcode, so a runaway core idles instead of seeing unknowns.
  assign prog_data  = (prog_addr < PC_W'(128)) ? prog_mem[prog_addr[6:1]] : 16'hffff;
  assign dmem_rdata = data_mem[dmem_req.addr];

  // The core raises we for the Q4 clock only; the byte lands at the edge that ends Q4.
  always @(posedge sys_clk) begin
    if (clk_en && dmem_req.we === 1'b1) begin
      data_mem[dmem_req.addr] <= dmem_req.wdata;
    end
  end
endmodule : cab_mem_model

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst_n, clk_en, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [20:0] prog_addr, last_addr;
  logic [15:0] prog_data;
  logic [7:0]  dmem_rdata;
  cab_pkg::cab_dmem_req_type dmem_req;
  int fail_count, samples_checked, cyc, last_cyc;
  int gaps[$];
  logic [20:0] addrs[$];

  cab_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
  cab_mem_model mem (.sys_clk(sys_clk), .clk_en(clk_en), .prog_addr(prog_addr), .prog_data(prog_data),
    .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));

  // A 40 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Fetch addresses and the clocks between them, so branch cycle counts show up as gaps.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rst_n && prog_addr !== last_addr) begin
      addrs.push_back(prog_addr);
      gaps.push_back(cyc - last_cyc);
      last_cyc <= cyc;
    end
    last_addr <= prog_addr;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One Avalon transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic reset_state();
    bus(1'b0, cab_pkg::OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    bus(1'b0, cab_pkg::OFS_STATUS, 32'h0);
    check("status", rd, 32'h0);
    bus(1'b0, 5'h18, 32'h0); // Unmapped offset reads zero.
    check("unmapped", rd, 32'h0);
  endtask : reset_state

  // A short program touching every opcode, both destinations, both banks and both branch outcomes.
  task automatic run_program();
    int exp_gap[9] = '{4, 4, 4, 4, 4, 4, 4, 4, 8};
    mem.prog_mem[0]  = 16'h2120;
    mem.prog_mem[1]  = 16'h0b5f;
    mem.prog_mem[2]  = 16'h1721;
    mem.prog_mem[3]  = 16'h9e80;
    mem.prog_mem[4]  = 16'he205;
    mem.prog_mem[5]  = 16'h0b80;
    mem.prog_mem[6]  = 16'h2210;
    mem.prog_mem[7]  = 16'he602;
    mem.prog_mem[8]  = 16'h0b00;
    mem.prog_mem[9]  = 16'h0b00;
    mem.prog_mem[11] = 16'he6ff;
    mem.data_mem[12'h120] = 8'h02;
    mem.data_mem[12'h121] = 8'hc2;
    mem.data_mem[12'hf80] = 8'hc7;
    mem.data_mem[12'h010] = 8'hff;
    bus(1'b1, cab_pkg::OFS_WREG, 32'h4d);
    bus(1'b1, cab_pkg::OFS_STATUS, 32'h01);
    bus(1'b1, cab_pkg::OFS_BANK_SEL, 32'h01);
    bus(1'b1, cab_pkg::OFS_CTRL, 32'h01);
    gaps.delete();
    addrs.delete();
    repeat (80) @(posedge sys_clk);
    bus(1'b1, cab_pkg::OFS_CTRL, 32'h00);
    check("fetch count", addrs.size(), 32'd9);
    for (int i = 1; i < 9 && i < addrs.size(); i++) begin
      check("fetch gap", gaps[i], exp_gap[i]);
    end
    check("taken target", addrs[7], 32'd20);
    check("file 121", mem.data_mem[12'h121], 8'h40);
    check("file f80", mem.data_mem[12'hf80], 8'h47);
    check("file 010", mem.data_mem[12'h010], 8'hff);
    check("file 110", mem.data_mem[12'h110], 8'h00);
    check("file 120", mem.data_mem[12'h120], 8'h02);
    bus(1'b0, cab_pkg::OFS_WREG, 32'h0);
    check("w", rd, 32'h00);
    bus(1'b0, cab_pkg::OFS_STATUS, 32'h0);
    check("status", rd, 32'h10);
  endtask : run_program

  // Extended set on: a low file address is offset from the index base, a high one stays in the access bank.
  // The counter is moved over the bus first, and the clock enable is dropped for a while mid-run.
  task automatic run_indexed();
    mem.prog_mem[24] = 16'h1605;
    mem.prog_mem[25] = 16'h9070;
    mem.data_mem[12'h2a5] = 8'h5a;
    mem.data_mem[12'hf70] = 8'hff;
    bus(1'b1, cab_pkg::OFS_WREG, 32'h0f);
    bus(1'b1, cab_pkg::OFS_INDEX_BASE, 32'h2a0);
    bus(1'b0, cab_pkg::OFS_INDEX_BASE, 32'h0);
    check("index base", rd, 32'h2a0);
    bus(1'b1, cab_pkg::OFS_PC, 32'h30);
    bus(1'b1, cab_pkg::OFS_CTRL, 32'h03);
    repeat (6) @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (5) @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (40) @(posedge sys_clk);
    bus(1'b1, cab_pkg::OFS_CTRL, 32'h00);
    check("file 2a5", mem.data_mem[12'h2a5], 8'h0a);
    check("file f70", mem.data_mem[12'hf70], 8'hfe);
    bus(1'b0, cab_pkg::OFS_STATUS, 32'h0);
    check("status", rd, 32'h00);
  endtask : run_indexed

  task automatic complete_run();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {cyc, last_cyc, fail_count, samples_checked} = '0;
    clk_en = 1'b1;
    avs_byteenable = 4'hf;
    last_addr = '0;
    for (int i = 0; i < 4096; i++) mem.data_mem[i] = 8'h00;
    for (int i = 0; i < 64; i++) mem.prog_mem[i] = 16'hffff;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    reset_state();
    run_program();
    run_indexed();
    complete_run();
  end
endmodule : testbench
